// ### logic/smbus_pec_consts.svh
// Constants for the SMBus error-code and factory-access block
`ifndef SMBUS_PEC_CONSTS_SVH
`define SMBUS_PEC_CONSTS_SVH
`define SLAVE_ADDR 7'h0B
`define CMD_FACTORY 8'h00
`define SUB_PART 16'h0001
`define SUB_FWREV 16'h0002
`define SUB_END_DISCH 16'h0003
`define SUB_STATUS 16'h0004
`define SUB_SHIP 16'h0005
`define SUB_SEAL 16'h062B
`define STATUS_LOW_BYTE 8'h0A
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
`define CODE_WAKE 4'h0
`define CODE_NORMAL 4'h1
`define CODE_PRECHG 4'h3
`define CODE_SUSP 4'h4
`define CODE_CHARGE 4'h5
`define CODE_TERM 4'h7
`define CODE_FAULT_TERM 4'h8
`define CODE_PERM_FAIL 4'h9
`define CODE_OVERCUR 4'hA
`define CODE_BATT_FAIL 4'hC
`define CODE_SLEEP 4'hD
`define TOPO_ZV 2'h0
`define TOPO_COMMON 2'h1
`define TOPO_PRE 2'h2
`define CLK_KHZ 250000
`define BUS_OFF_TIME_MS 2000
`define BUS_OFF_CYCLES (`BUS_OFF_TIME_MS * `CLK_KHZ)
`endif

// ### logic/smbus_pec_pkg.sv
// Types for the SMBus error-code and factory-access block
package smbus_pec_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RXACK = 3'b011,
    ST_TX = 3'b010,
    ST_TXACK = 3'b110
  } slave_state_t;
endpackage

// ### logic/smbus_pec_factory_access.sv
// SMBus slave with error-code check, bus-off detect, factory access and switch control
// How it works
// - Error code is CRC-8 with polynomial x^8+x^2+x+1.
// - Code covers address, command and data bytes of the message.
// - Acknowledge bits, start, stop and repeated start are not hashed.
// - Read-word code covers write address, command, read address, low, high byte.
// - Broadcast error code appended per host and charger enable bits.
// - Bus off after both lines low for 2.0 s without break.
// - Bus on as soon as both lines return high, well under 1 ms.
// - Word reads of command 0x00 return the word chosen by the last sub-code 1..4 written since reset or seal, else the factory word.
// - Sub-codes 1..4 return part type, firmware, end-discharge level, pack status.
// - Sub-code 0x062B seals the device and clears the factory word.
// - Pack status: switches 15:14, cause 13:12, code 11:8, low byte 0x0A.
// - Switch field encodes charge and discharge switch states.
// - Failure cause shown only when the code means permanent failure.
// - Pack condition codes follow the fixed state table.
// - Charge switch forced on while discharge current exceeds detection level.
// - Wake-up and precharge turn charge switch on only for common topology.
// - Wake-up turns zero-volt switch on for topology 00 or 02.
// - Battery-fail and overcurrent states keep the charge switch on for non-removable packs.
// - Sleep turns both switches off, discharge stays on if non-removable.
// - Slave answers at address 0001011, direction in address bit 0.
// - Wrong host error code is refused with not-acknowledge and flagged.
`timescale 1ns/1ns
`include "smbus_pec_consts.svh"
module smbus_pec_factory_access #(
  parameter logic [31:0] BUS_OFF_CYCLES = `BUS_OFF_CYCLES,
  parameter logic [15:0] PART_TYPE = 16'h5A5A,
  parameter logic [15:0] FW_REV = 16'h0100
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] pack_condition_code,
  input wire logic [1:0] failure_cause,
  input wire logic dsg_over_detect,
  input wire logic [1:0] switch_topology_setting,
  input wire logic nonremovable_option,
  input wire logic [15:0] end_discharge_level,
  input wire logic host_broadcast_crc_enable,
  input wire logic charger_broadcast_crc_enable,
  input wire logic broadcast_to_charger,
  output logic broadcast_pec_append,
  output logic charge_switch,
  output logic discharge_switch,
  output logic zero_volt_charge_switch,
  output logic precharge_path_switch,
  output logic ship_request,
  output logic sealed,
  output logic pec_error,
  output logic bus_off
);

  // ************************************
  // Helpers
  // ************************************
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic subcode_known(input logic [15:0] w);
    return (w == `SUB_PART) || (w == `SUB_FWREV) || (w == `SUB_END_DISCH) || (w == `SUB_STATUS);
  endfunction

  // ************************************
  // Pin sampling and bus off
  // ************************************
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [31:0] off_cnt, next_off_cnt;
  logic next_bus_off;
  logic scl_rise, scl_fall, start_c, stop_c;

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
  assign sda_out = 1'b0;

  always_comb begin
    next_off_cnt = off_cnt;
    next_bus_off = bus_off;
    if (scl_s | sda_s) begin
      next_off_cnt = 32'h0;
      if (scl_s & sda_s) begin
        next_bus_off = 1'b0;
      end
    end else if (off_cnt >= BUS_OFF_CYCLES - 32'h1) begin
      next_bus_off = 1'b1;
    end else begin
      next_off_cnt = off_cnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      off_cnt <= 32'h0;
      bus_off <= 1'b0;
    end else if (ce) begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      off_cnt <= next_off_cnt;
      bus_off <= next_bus_off;
    end
  end

  // ************************************
  // Switch control and pack status
  // ************************************
  logic next_chg, next_dsg, next_zv, next_od, next_bpa;
  logic [15:0] pack_status;

  always_comb begin
    next_chg = 1'b0;
    next_dsg = 1'b0;
    next_zv = 1'b0;
    next_od = 1'b0;
    case (pack_condition_code)
      `CODE_WAKE: begin
        next_chg = switch_topology_setting == `TOPO_COMMON;
        next_dsg = 1'b1;
        next_zv = (switch_topology_setting == `TOPO_ZV) || (switch_topology_setting == `TOPO_PRE);
      end
      `CODE_PRECHG: begin
        next_chg = switch_topology_setting == `TOPO_COMMON;
        next_dsg = 1'b1;
        next_zv = switch_topology_setting == `TOPO_ZV;
        next_od = switch_topology_setting == `TOPO_PRE;
      end
      `CODE_SUSP, `CODE_TERM, `CODE_FAULT_TERM: next_dsg = 1'b1;
      `CODE_CHARGE, `CODE_NORMAL: begin
        next_chg = 1'b1;
        next_dsg = 1'b1;
      end
      `CODE_BATT_FAIL, `CODE_OVERCUR: next_chg = nonremovable_option;
      `CODE_SLEEP: next_dsg = nonremovable_option;
      default: next_chg = 1'b0;
    endcase
    if (dsg_over_detect) begin
      next_chg = 1'b1;
    end
    next_bpa = broadcast_to_charger ? charger_broadcast_crc_enable : host_broadcast_crc_enable;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      charge_switch <= 1'b0;
      discharge_switch <= 1'b0;
      zero_volt_charge_switch <= 1'b0;
      precharge_path_switch <= 1'b0;
      broadcast_pec_append <= 1'b0;
    end else if (ce) begin
      charge_switch <= next_chg;
      discharge_switch <= next_dsg;
      zero_volt_charge_switch <= next_zv;
      precharge_path_switch <= next_od;
      broadcast_pec_append <= next_bpa;
    end
  end

  assign pack_status = {~discharge_switch, charge_switch ^ discharge_switch,
    (pack_condition_code == `CODE_PERM_FAIL) ? failure_cause : 2'b00,
    pack_condition_code, `STATUS_LOW_BYTE};

  // ************************************
  // SMBus slave
  // ************************************
  smbus_pec_pkg::slave_state_t state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg, crc, next_crc, cmd, next_cmd, ld;
  logic [2:0] wcount, next_wcount;
  logic [1:0] tidx, next_tidx;
  logic [15:0] wdata, next_wdata, factory_word, next_factory_word, sel, next_sel, rd_word;
  logic addr_phase, next_addr_phase, rw_read, next_rw_read, next_oe;
  logic next_pec_error, next_ship, next_sealed, byte_done, commit;

  always_comb begin
    case (sel)
      `SUB_PART: rd_word = PART_TYPE;
      `SUB_FWREV: rd_word = FW_REV;
      `SUB_END_DISCH: rd_word = end_discharge_level;
      `SUB_STATUS: rd_word = pack_status;
      default: rd_word = factory_word;
    endcase
    if (cmd != `CMD_FACTORY) begin
      rd_word = 16'h0000;
    end
  end

  assign byte_done = (state == smbus_pec_pkg::ST_RX) && scl_fall && (bitcnt == 4'h8) && !bus_off;
  assign commit = stop_c && !bus_off && !rw_read && (cmd == `CMD_FACTORY) &&
    ((wcount == 3'h3) || (wcount == 3'h4));

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_crc = crc;
    next_cmd = cmd;
    next_wcount = wcount;
    next_tidx = tidx;
    next_wdata = wdata;
    next_factory_word = factory_word;
    next_sel = sel;
    next_addr_phase = addr_phase;
    next_rw_read = rw_read;
    next_oe = sda_oe;
    next_pec_error = pec_error;
    next_ship = 1'b0;
    next_sealed = sealed;
    ld = 8'hFF;
    if (bus_off) begin
      next_state = smbus_pec_pkg::ST_IDLE;
      next_oe = 1'b0;
    end else if (start_c) begin
      next_state = smbus_pec_pkg::ST_RX;
      next_bitcnt = 4'h0;
      next_addr_phase = 1'b1;
      next_oe = 1'b0;
      if (state == smbus_pec_pkg::ST_IDLE) begin
        next_crc = `CRC_INIT;
        next_wcount = 3'h0;
        next_rw_read = 1'b0;
      end
    end else if (stop_c) begin
      next_state = smbus_pec_pkg::ST_IDLE;
      next_oe = 1'b0;
      if (commit) begin
        next_factory_word = wdata;
        if (subcode_known(wdata)) begin
          next_sel = wdata;
        end
        if (wdata == `SUB_SHIP && !sealed) begin
          next_ship = 1'b1;
        end
        if (wdata == `SUB_SEAL) begin
          next_sealed = 1'b1;
          next_factory_word = 16'h0000;
          next_sel = 16'h0000;
        end
      end
    end else begin
      case (state)
        smbus_pec_pkg::ST_RX: begin
          if (scl_rise && bitcnt < 4'h8) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (byte_done) begin
            next_state = smbus_pec_pkg::ST_RXACK;
            next_oe = 1'b1;
            if (addr_phase) begin
              if (shreg[7:1] == `SLAVE_ADDR) begin
                next_crc = crc8(crc, shreg);
                next_rw_read = shreg[0];
                next_addr_phase = 1'b0;
              end else begin
                next_state = smbus_pec_pkg::ST_IDLE;
                next_oe = 1'b0;
              end
            end else if (wcount == 3'h3) begin
              if (shreg == crc) begin
                next_wcount = 3'h4;
              end else begin
                next_pec_error = 1'b1;
                next_wcount = 3'h0;
                next_state = smbus_pec_pkg::ST_IDLE;
                next_oe = 1'b0;
              end
            end else begin
              next_crc = crc8(crc, shreg);
              if (wcount != 3'h5) begin
                next_wcount = wcount + 3'h1;
              end
              if (wcount == 3'h0) begin
                next_cmd = shreg;
              end
              if (wcount == 3'h1) begin
                next_wdata = {wdata[15:8], shreg};
              end
              if (wcount == 3'h2) begin
                next_wdata = {shreg, wdata[7:0]};
              end
            end
          end
        end
        smbus_pec_pkg::ST_RXACK: begin
          if (scl_fall) begin
            next_bitcnt = 4'h0;
            next_oe = 1'b0;
            next_state = smbus_pec_pkg::ST_RX;
            if (rw_read) begin
              next_wdata = rd_word;
              next_shreg = rd_word[7:0];
              next_crc = crc8(crc, rd_word[7:0]);
              next_tidx = 2'h0;
              next_oe = ~rd_word[7];
              next_state = smbus_pec_pkg::ST_TX;
            end
          end
        end
        smbus_pec_pkg::ST_TX: begin
          if (scl_rise && bitcnt < 4'h8) begin
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            next_oe = 1'b0;
            next_state = smbus_pec_pkg::ST_TXACK;
          end else if (scl_fall) begin
            next_oe = ~shreg[6];
            next_shreg = {shreg[6:0], 1'b0};
          end
        end
        smbus_pec_pkg::ST_TXACK: begin
          if (scl_rise && sda_s) begin
            next_state = smbus_pec_pkg::ST_IDLE;
          end else if (scl_fall) begin
            case (tidx)
              2'h0: ld = wdata[15:8];
              2'h1: ld = crc;
              default: ld = 8'hFF;
            endcase
            if (tidx == 2'h0) begin
              next_crc = crc8(crc, ld);
            end
            if (tidx != 2'h3) begin
              next_tidx = tidx + 2'h1;
            end
            next_shreg = ld;
            next_bitcnt = 4'h0;
            next_oe = ~ld[7];
            next_state = smbus_pec_pkg::ST_TX;
          end
        end
        default: next_state = smbus_pec_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= smbus_pec_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      crc <= `CRC_INIT;
      cmd <= 8'hFF;
      wcount <= 3'h0;
      tidx <= 2'h0;
      wdata <= 16'h0000;
      factory_word <= 16'h0000;
      sel <= 16'h0000;
      addr_phase <= 1'b0;
      rw_read <= 1'b0;
      sda_oe <= 1'b0;
      pec_error <= 1'b0;
      ship_request <= 1'b0;
      sealed <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      crc <= next_crc;
      cmd <= next_cmd;
      wcount <= next_wcount;
      tidx <= next_tidx;
      wdata <= next_wdata;
      factory_word <= next_factory_word;
      sel <= next_sel;
      addr_phase <= next_addr_phase;
      rw_read <= next_rw_read;
      sda_oe <= next_oe;
      pec_error <= next_pec_error;
      ship_request <= next_ship;
      sealed <= next_sealed;
    end
  end

  // ************************************
  // Checks
  // ************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !ce);

  a_crc_restart: assert property ((start_c && !bus_off && state == smbus_pec_pkg::ST_IDLE) |=> crc == 8'h00)
    else $error("crc not cleared at start");
  a_addr_match: assert property ((byte_done && addr_phase && shreg[7:1] == `SLAVE_ADDR) |=> sda_oe)
    else $error("own address not acknowledged");
  a_addr_other: assert property ((byte_done && addr_phase && shreg[7:1] != `SLAVE_ADDR) |=> !sda_oe && state == smbus_pec_pkg::ST_IDLE)
    else $error("foreign address acknowledged");
  a_pec_refuse: assert property ((byte_done && !addr_phase && wcount == 3'h3 && shreg != crc) |=> pec_error && !sda_oe)
    else $error("bad error code not refused");
  a_bus_off_set: assert property ((!scl_s && !sda_s && off_cnt == BUS_OFF_CYCLES - 32'h1) |=> bus_off)
    else $error("bus off not declared");
  a_bus_on_fast: assert property ((bus_off && scl_s && sda_s) |=> !bus_off)
    else $error("bus on late");
  a_sw_charge: assert property ((pack_condition_code == `CODE_CHARGE) |=> pack_status[15:14] == 2'b00)
    else $error("switch field wrong in charge");
  a_sleep_off: assert property ((pack_condition_code == `CODE_SLEEP && !dsg_over_detect && !nonremovable_option)
    |=> !charge_switch && !discharge_switch)
    else $error("switch on in sleep");
  a_over_chg: assert property (dsg_over_detect |=> charge_switch)
    else $error("charge switch off under discharge");
  a_seal_clear: assert property ((commit && wdata == `SUB_SEAL) |=> sealed && factory_word == 16'h0000)
    else $error("seal did not clear word");
  a_ship_pulse: assert property ((commit && wdata == `SUB_SHIP && !sealed) |=> ship_request ##1 !ship_request)
    else $error("ship request not one pulse");

  c_write_commit: cover property (commit);
  c_read_pec: cover property (state == smbus_pec_pkg::ST_TXACK && tidx == 2'h2);
  c_bus_off: cover property ($rose(bus_off));

endmodule

// ### verification/smbus_host_model.sv
// SMBus host master model that drives the far side of the link
`timescale 1ns/1ns
module smbus_host_model (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic master_pull,
  output logic rd_done,
  output logic [15:0] rd_data,
  output logic rd_pec_ok
);
  logic r;
  initial begin
    scl = 1'b1;
    master_pull = 1'b0;
    rd_done = 1'b0;
    rd_data = 16'h0000;
    rd_pec_ok = 1'b0;
  end
  // ****************
  // Error code and bit timing
  // ****************
  function automatic logic [7:0] crc_upd(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
    end
    return x;
  endfunction
  task automatic half();
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    master_pull = !b;
    half();
    scl = 1'b1;
    half();
    s = sda;
    scl = 1'b0;
  endtask
  task automatic start_c();
    master_pull = 1'b0;
    half();
    scl = 1'b1;
    half();
    master_pull = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop_c();
    master_pull = 1'b1;
    half();
    scl = 1'b1;
    half();
    master_pull = 1'b0;
    half();
  endtask
  task automatic tx(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rx(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!ack, r);
  endtask
  // ****************
  // Word transfers
  // ****************
  // Mode 0 no error code, 1 good code, 2 corrupted code
  task automatic wr(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] w, input int mode,
                    output logic all_ack);
    logic [7:0] q [5];
    logic [7:0] c;
    logic a;
    q = '{{addr, 1'b0}, cmd, w[7:0], w[15:8], 8'h00};
    c = 8'h00;
    for (int i = 0; i < 4; i++) c = crc_upd(c, q[i]);
    q[4] = (mode == 2) ? ~c : c;
    all_ack = 1'b1;
    start_c();
    for (int i = 0; i < ((mode != 0) ? 5 : 4); i++) begin
      tx(q[i], a);
      all_ack &= a;
    end
    stop_c();
  endtask
  task automatic rd(input logic [7:0] cmd);
    logic [7:0] lo, hi, p, c;
    logic a;
    start_c();
    tx(8'h16, a);
    tx(cmd, a);
    start_c();
    tx(8'h17, a);
    rx(1'b1, lo);
    rx(1'b1, hi);
    rx(1'b0, p);
    stop_c();
    c = crc_upd(crc_upd(crc_upd(crc_upd(crc_upd(8'h00, 8'h16), cmd), 8'h17), lo), hi);
    rd_data = {hi, lo};
    rd_pec_ok = (p === c);
    rd_done = 1'b1;
    @(negedge sys_clk);
    rd_done = 1'b0;
  endtask
  task automatic hold_bus(input logic low);
    scl = !low;
    master_pull = low;
  endtask
endmodule

// ### verification/tb_smbus_pec_factory_access.sv
// Self-checking testbench for the SMBus error-code and factory-access block
`timescale 1ns/1ns
module tb_smbus_pec_factory_access;
  localparam logic [15:0] PART = 16'h3C3C; // Arbitrary part-type value
  localparam logic [15:0] FW = 16'h0042; // Arbitrary revision value
  localparam logic [15:0] TBL [16] = '{16'h14CF, 16'h006F, 16'h086F, 16'h3488, 16'h3008, 16'hD00C,
                                       16'hD24C, 16'hD188, 16'hC28C, 16'hC00C, 16'h900F, 16'h54CF,
                                       16'h444F, 16'h385F, 16'hA28F, 16'hF00F};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic scl, pull, sda_out, sda_oe, rd_done, rd_pec_ok, a, sda_in, scl_in;
  logic [15:0] rd_data, st;
  logic [3:0] pack_condition_code = 4'h1;
  logic [1:0] failure_cause = 2'h0;
  logic [1:0] switch_topology_setting = 2'h1;
  logic dsg_over_detect = 1'b0;
  logic nonremovable_option = 1'b0;
  logic [15:0] end_discharge_level = 16'h0000;
  logic host_broadcast_crc_enable = 1'b0;
  logic charger_broadcast_crc_enable = 1'b0;
  logic broadcast_to_charger = 1'b0;
  logic broadcast_pec_append, charge_switch, discharge_switch, zero_volt_charge_switch, precharge_path_switch;
  logic ship_request, sealed, pec_error, bus_off;
  logic [15:0] exp_q [$];
  int n_fail = 0;
  int n_compared = 0;
  int n_ship = 0;
  int cycles = 0;
  int seed = 32'h2664;
  assign sda_in = !((sda_oe & !sda_out) | pull);
  assign scl_in = scl;
  always #2 sys_clk = ~sys_clk;
  smbus_pec_factory_access #(.BUS_OFF_CYCLES(32'h000000C8), .PART_TYPE(PART), .FW_REV(FW)) i_dut (
    .sys_clk, .rst_n, .ce, .scl_in, .sda_in, .sda_out, .sda_oe, .pack_condition_code, .failure_cause,
    .dsg_over_detect, .switch_topology_setting, .nonremovable_option, .end_discharge_level,
    .host_broadcast_crc_enable, .charger_broadcast_crc_enable, .broadcast_to_charger, .broadcast_pec_append,
    .charge_switch, .discharge_switch, .zero_volt_charge_switch, .precharge_path_switch, .ship_request,
    .sealed, .pec_error, .bus_off);
  smbus_host_model i_host (.sys_clk(sys_clk), .sda(sda_in), .scl(scl), .master_pull(pull), .rd_done(rd_done),
    .rd_data(rd_data), .rd_pec_ok(rd_pec_ok));
  // ****************
  // Checking
  // ****************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge rd_done) begin
    check(rd_data, exp_q.pop_front());
    check({15'h0, rd_pec_ok}, 16'h0001);
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (ship_request === 1'b1) n_ship++;
    if (cycles == 60000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic rd_exp(input logic [15:0] exp);
    exp_q.push_back(exp);
    i_host.rd(8'h00);
  endtask
  task automatic wr_ok(input logic [15:0] w);
    i_host.wr(7'h0B, 8'h00, w, 1, a);
    check({15'h0, a}, 16'h0001);
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    end_discharge_level = 16'($random(seed));
    failure_cause = 2'($random(seed));
    pack_condition_code = 4'h9;
    st = {2'b10, failure_cause, 4'h9, 8'h0A};
    wr_ok(16'h0001);
    rd_exp(PART);
    wr_ok(16'h0002);
    rd_exp(FW);
    wr_ok(16'h0003);
    rd_exp(end_discharge_level);
    wr_ok(16'h0004);
    rd_exp(st);
    pack_condition_code = 4'h1;
    rd_exp(16'h010A);
    wr_ok(16'h7777);
    rd_exp(16'h010A);
    i_host.wr(7'h0B, 8'h00, 16'h0002, 2, a);
    check({15'h0, a}, 16'h0000);
    check({15'h0, pec_error}, 16'h0001);
    i_host.wr(7'h0C, 8'h00, 16'h0002, 1, a);
    check({15'h0, a}, 16'h0000);
    rd_exp(16'h010A);
    i_host.wr(7'h0B, 8'h00, 16'h0001, 0, a);
    check({15'h0, a}, 16'h0001);
    rd_exp(PART);
    wr_ok(16'h0005);
    check(n_ship[15:0], 16'h0001);
    wr_ok(16'h062B);
    check({15'h0, sealed}, 16'h0001);
    rd_exp(16'h0000);
    foreach (TBL[i]) begin
      {pack_condition_code, switch_topology_setting, nonremovable_option, dsg_over_detect} = TBL[i][15:8];
      repeat (2) @(negedge sys_clk);
      check({12'h0, {charge_switch, discharge_switch, zero_volt_charge_switch, precharge_path_switch} & TBL[i][3:0]},
            {12'h0, TBL[i][7:4]});
    end
    for (int i = 0; i < 8; i++) begin
      {broadcast_to_charger, host_broadcast_crc_enable, charger_broadcast_crc_enable} = i[2:0];
      repeat (2) @(negedge sys_clk);
      check({15'h0, broadcast_pec_append}, {15'h0, i[2] ? i[0] : i[1]});
    end
    i_host.hold_bus(1'b1);
    repeat (190) @(negedge sys_clk);
    check({15'h0, bus_off}, 16'h0000);
    repeat (20) @(negedge sys_clk);
    check({15'h0, bus_off}, 16'h0001);
    i_host.hold_bus(1'b0);
    repeat (6) @(negedge sys_clk);
    check({15'h0, bus_off}, 16'h0000);
    rd_exp(16'h0000);
    repeat (20) @(negedge sys_clk);
    check(16'(exp_q.size()), 16'h0000);
    stop_test();
  end
endmodule
